// File: core/timer_prescaler_pkg.sv
package timer_prescaler_pkg;

  // ==========================================================================
  // register map (byte addresses on apb)
  // ==========================================================================
  localparam logic [11:0] event_flags_addr    = 12'h000;
  localparam logic [11:0] shared_control_addr = 12'h004;
  localparam logic [11:0] timer_config_addr   = 12'h008;
  localparam logic [11:0] compare_a_addr      = 12'h00c;
  localparam logic [11:0] compare_b_addr      = 12'h010;
  localparam logic [11:0] counter_addr        = 12'h014;
  localparam logic [11:0] capture_addr        = 12'h018;
  localparam logic [11:0] vector_ack_addr     = 12'h01c;

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int capture_flag_bit      = 5;
  localparam int compare_b_flag_bit    = 2;
  localparam int compare_a_flag_bit    = 1;
  localparam int overflow_flag_bit     = 0;
  localparam int sync_hold_mode_bit    = 7;
  localparam int capture_select_bit    = 6;
  localparam int prescaler_reset_pos   = 0;
  localparam logic [7:0] flags_mask    = 8'h27;
  localparam logic [7:0] control_mask  = 8'hc1;

  // timer_config layout: [2:0] clock select, [6:3] waveform mode,
  // [8] force a, [9] force b, [10] capture edge (1 = rising)
  localparam int cs_lsb        = 0;
  localparam int wgm_lsb       = 3;
  localparam int force_a_bit   = 8;
  localparam int force_b_bit   = 9;
  localparam int cap_edge_bit  = 10;

  // ==========================================================================
  // reset values and encodings
  // ==========================================================================
  localparam logic [7:0]  flags_reset    = 8'h00;
  localparam logic [7:0]  control_reset  = 8'h00;
  localparam logic [10:0] config_reset   = 11'h000;
  localparam logic [15:0] counter_top    = 16'hffff;

  typedef enum logic [2:0] {
    cs_stopped = 3'h0, cs_div1 = 3'h1, cs_div8 = 3'h2, cs_div64 = 3'h3,
    cs_div256 = 3'h4, cs_div1024 = 3'h5, cs_ext_fall = 3'h6, cs_ext_rise = 3'h7
  } clock_select_e;

  localparam logic [3:0] wgm_normal      = 4'h0;
  localparam logic [3:0] wgm_ctc_compare = 4'h4;
  localparam logic [3:0] wgm_ctc_capture = 4'hc;

  // prescaler tap divisors
  localparam int div_8    = 8;
  localparam int div_64   = 64;
  localparam int div_256  = 256;
  localparam int div_1024 = 1024;
  localparam int prescale_width = 10;

  typedef struct packed {
    logic capture;
    logic compare_b;
    logic compare_a;
    logic overflow;
  } flag_events_s;

endpackage

// File: core/pin_sampler.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sampler
  import timer_prescaler_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  // pin and result
  input  wire logic pin,
  output logic      sampled
);

  // ==========================================================================
  // two-stage sampler
  // ==========================================================================
  logic meta;

  // first stage stands in for the clock-high latch; only stage two reads it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta    <= 1'b0;
      sampled <= 1'b0;
    end else if (clk_en) begin
      meta    <= pin;
      sampled <= meta;
    end
  end

endmodule
`default_nettype wire

// File: core/timer_prescaler.sv
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module timer_prescaler
  import timer_prescaler_pkg::*;
(
  // apb clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pins
  input  wire logic        ext_timer_clock_pin,
  input  wire logic        capture_pin_first,
  input  wire logic        capture_pin_second,
  // interrupt gating from the core
  input  wire logic [3:0]  irq_enable,
  input  wire logic        global_irq_enable,
  output logic      [3:0]  irq_request,
  // prescaler taps and hold status for the 8-bit timer
  output logic      [3:0]  prescaler_taps,
  output logic             prescaler_held
);

  // ==========================================================================
  // registers and nets
  // ==========================================================================
  logic [7:0]  timer1_event_flags;
  logic [7:0]  shared_timer_control;
  logic [10:0] timer_config;
  logic [15:0] compare_a_value;
  logic [15:0] compare_b_value;
  logic [15:0] counter_value;
  logic [15:0] capture_value_reg;
  logic [prescale_width-1:0] prescale_count;
  logic        ext_sampled;
  logic        ext_prev;
  logic        cap_first_s;
  logic        cap_second_s;
  logic        cap_prev;
  logic        timer_tick;
  logic        match_a_pend;
  logic        match_b_pend;
  logic        counter_written;
  logic [3:0]  next_taps;
  logic        wr_access;
  logic        rd_access;
  logic        flag_write;
  logic        ctl_write;
  logic        cfg_write;
  logic        cnt_write;
  logic        ack_write;
  logic [2:0]  clock_select_field;
  logic [3:0]  waveform_mode_field;
  logic        cap_pin;
  logic        cap_event;
  logic        at_top;
  logic        ext_rise;
  logic        ext_fall;
  logic [15:0] top_value;
  flag_events_s hw_set;
  logic [7:0]  clear_mask;

  // writes land only on the completing access cycle, so a self-clearing bit is not written twice
  assign wr_access           = psel && penable && pwrite && pready;
  assign rd_access           = psel && penable && !pwrite;
  assign flag_write          = wr_access && (paddr == event_flags_addr) && pstrb[0];
  assign ctl_write           = wr_access && (paddr == shared_control_addr) && pstrb[0];
  assign cfg_write           = wr_access && (paddr == timer_config_addr);
  assign cnt_write           = wr_access && (paddr == counter_addr);
  assign ack_write           = wr_access && (paddr == vector_ack_addr) && pstrb[0];
  assign clock_select_field  = timer_config[cs_lsb +: 3];
  assign waveform_mode_field = timer_config[wgm_lsb +: 4];

  // ==========================================================================
  // pin synchronisers
  // ==========================================================================
  // external pin sampling
  pin_sampler u_ext_sync (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
                          .pin(ext_timer_clock_pin), .sampled(ext_sampled));
  pin_sampler u_cap1_sync (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
                           .pin(capture_pin_first), .sampled(cap_first_s));
  pin_sampler u_cap2_sync (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
                           .pin(capture_pin_second), .sampled(cap_second_s));

  // previous samples for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev <= 1'b0;
      cap_prev <= 1'b0;
    end else if (clk_en) begin
      ext_prev <= ext_sampled;
      cap_prev <= cap_pin;
    end
  end

  assign cap_pin  = shared_timer_control[capture_select_bit] ? cap_second_s : cap_first_s;
  assign ext_rise = ext_sampled && !ext_prev;
  assign ext_fall = !ext_sampled && ext_prev;

  // ==========================================================================
  // shared prescaler
  // ==========================================================================
  // free-running count, stopped by the reset bit or by clk_en low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_count <= '0;
    end else if (clk_en) begin
      if (shared_timer_control[prescaler_reset_pos])
        prescale_count <= '0;
      else
        prescale_count <= prescale_count + 1'b1;
    end
  end

  // tap pulses, one pclk wide, at the wrap of each divisor
  always_comb begin
    next_taps[0] = prescale_count[2:0] == 3'h7;
    next_taps[1] = prescale_count[5:0] == 6'h3f;
    next_taps[2] = prescale_count[7:0] == 8'hff;
    next_taps[3] = prescale_count == 10'h3ff;
    if (shared_timer_control[prescaler_reset_pos])
      next_taps = 4'h0;
  end

  // taps exported so the 8-bit timer shares the same phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescaler_taps <= 4'h0;
      prescaler_held <= 1'b0;
    end else if (clk_en) begin
      prescaler_taps <= next_taps;
      prescaler_held <= shared_timer_control[prescaler_reset_pos];
    end
  end

  // ==========================================================================
  // timer clock select
  // ==========================================================================
  always_comb begin
    unique case (clock_select_field)
      cs_stopped:  timer_tick = 1'b0;
      cs_div1:     timer_tick = 1'b1;
      cs_div8:     timer_tick = next_taps[0];
      cs_div64:    timer_tick = next_taps[1];
      cs_div256:   timer_tick = next_taps[2];
      cs_div1024:  timer_tick = next_taps[3];
      // edge pulses, no divider; sync plus edge stage
      cs_ext_fall: timer_tick = ext_fall;
      cs_ext_rise: timer_tick = ext_rise;
    endcase
    // prescaler reset halts every timer clock while asserted
    if (shared_timer_control[prescaler_reset_pos])
      timer_tick = 1'b0;
  end

  // ==========================================================================
  // 16-bit counter and capture
  // ==========================================================================
  assign top_value = (waveform_mode_field == wgm_ctc_compare) ? compare_a_value :
                     (waveform_mode_field == wgm_ctc_capture) ? capture_value_reg : counter_top;
  assign at_top    = counter_value == top_value;
  // capture pin disconnected while the capture register is top
  assign cap_event = (waveform_mode_field != wgm_ctc_capture) &&
                     (timer_config[cap_edge_bit] ? (cap_pin && !cap_prev) : (!cap_pin && cap_prev));

  // counter wraps at top; a bus write overrides counting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_value <= 16'h0000;
    end else if (clk_en) begin
      if (cnt_write)
        counter_value <= pwdata[15:0];
      else if (timer_tick)
        counter_value <= at_top ? 16'h0000 : counter_value + 16'h0001;
    end
  end

  // capture register and compare values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_value_reg <= 16'h0000;
      compare_a_value   <= 16'h0000;
      compare_b_value   <= 16'h0000;
    end else if (clk_en) begin
      if (wr_access && paddr == capture_addr)
        capture_value_reg <= pwdata[15:0];
      else if (cap_event)
        capture_value_reg <= counter_value;
      if (wr_access && paddr == compare_a_addr)
        compare_a_value <= pwdata[15:0];
      if (wr_access && paddr == compare_b_addr)
        compare_b_value <= pwdata[15:0];
    end
  end

  // match seen on a tick, flagged on the next tick; force strobes never enter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_a_pend    <= 1'b0;
      match_b_pend    <= 1'b0;
      counter_written <= 1'b0;
    end else if (clk_en) begin
      if (cnt_write)
        counter_written <= 1'b1;
      else if (timer_tick)
        counter_written <= 1'b0;
      if (timer_tick) begin
        // a counter write blocks the match on the following timer clock
        match_a_pend <= !counter_written && !cnt_write && (counter_value == compare_a_value);
        match_b_pend <= !counter_written && !cnt_write && (counter_value == compare_b_value);
      end
    end
  end

  // ==========================================================================
  // event flags
  // ==========================================================================
  always_comb begin
    hw_set.capture   = cap_event ||
                       (timer_tick && at_top && waveform_mode_field == wgm_ctc_capture);
    hw_set.compare_b = timer_tick && match_b_pend;
    hw_set.compare_a = timer_tick && match_a_pend;
    // overflow in normal and compare-clear modes; wrap at top otherwise
    hw_set.overflow  = timer_tick && (waveform_mode_field == wgm_normal ||
                       waveform_mode_field == wgm_ctc_compare) ? (counter_value == counter_top)
                       : (timer_tick && at_top);
    clear_mask = 8'h00;
    if (flag_write)
      clear_mask = clear_mask | pwdata[7:0];
    if (ack_write)
      clear_mask = clear_mask | pwdata[7:0];
  end

  // set wins over clear; reserved bits never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer1_event_flags <= flags_reset;
    end else if (clk_en) begin
      timer1_event_flags <= ((timer1_event_flags & ~clear_mask) |
                             {2'b00, hw_set.capture, 2'b00, hw_set.compare_b,
                              hw_set.compare_a, hw_set.overflow}) & flags_mask;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq_request <= 4'h0;
    else if (clk_en)
      irq_request <= {timer1_event_flags[capture_flag_bit], timer1_event_flags[compare_b_flag_bit],
                      timer1_event_flags[compare_a_flag_bit], timer1_event_flags[overflow_flag_bit]}
                     & irq_enable & {4{global_irq_enable}};
  end

  // ==========================================================================
  // shared control and timer configuration
  // ==========================================================================
  // reset bit kept only under sync hold mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shared_timer_control <= control_reset;
    end else if (clk_en) begin
      if (ctl_write)
        shared_timer_control <= pwdata[7:0] & control_mask;
      else if (!shared_timer_control[sync_hold_mode_bit])
        shared_timer_control[prescaler_reset_pos] <= 1'b0;
    end
  end

  // force strobes are not stored, so they always read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      timer_config <= config_reset;
    else if (clk_en && cfg_write)
      timer_config <= pwdata[10:0] & ~(11'h001 << force_a_bit) & ~(11'h001 << force_b_bit);
  end

  // ==========================================================================
  // apb response
  // ==========================================================================
  // one wait state; unmapped addresses answer with pslverr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && (paddr > vector_ack_addr || paddr[1:0] != 2'b00);
      prdata  <= 32'h0000_0000;
      if (rd_access && !pready) begin
        unique case (paddr)
          event_flags_addr:    prdata <= {24'h0, timer1_event_flags};
          shared_control_addr: prdata <= {24'h0, shared_timer_control};
          timer_config_addr:   prdata <= {21'h0, timer_config};
          compare_a_addr:      prdata <= {16'h0, compare_a_value};
          compare_b_addr:      prdata <= {16'h0, compare_b_value};
          counter_addr:        prdata <= {16'h0, counter_value};
          capture_addr:        prdata <= {16'h0, capture_value_reg};
          default:             prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// File: test/timer_prescaler_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module timer_prescaler_asserts
  import timer_prescaler_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // interrupt and prescaler
  input wire logic [3:0]  irq_enable,
  input wire logic        global_irq_enable,
  input wire logic [3:0]  irq_request,
  input wire logic [3:0]  prescaler_taps,
  input wire logic        prescaler_held
);
  // ==========================================
  // helpers
  // ==========================================
  // completing access cycle of a control write, where it takes effect
  wire ctl_wr = psel && penable && pready && pwrite && (paddr == shared_control_addr);

  default clocking cb @(posedge pclk); endclocking
  // frozen cycles hold pulses high, so they are not judged
  default disable iff (!presetn || !clk_en);

  AST_FLAGS_RESERVED_ZERO: assert property (
    pready && !pwrite && (paddr == event_flags_addr) |-> (prdata & ~{24'h0, flags_mask}) == 32'h0)
    else $error("reserved flag bits read nonzero");
  AST_IRQ_GATED: assert property (
    (irq_request & ~({4{$past(global_irq_enable)}} & $past(irq_enable))) == 4'h0)
    else $error("interrupt request without enable");
  AST_HELD_NO_TAPS: assert property (
    prescaler_held && $past(prescaler_held) |-> prescaler_taps == 4'h0)
    else $error("prescaler ticks while held");
  AST_TAPS_NESTED: assert property (
    (prescaler_taps[3:1] & ~prescaler_taps[2:0]) == 3'h0)
    else $error("slow tap without faster tap");
  AST_TAP8_GAP: assert property (
    prescaler_taps[0] |=> !prescaler_taps[0] [*7])
    else $error("divide by eight tap too soon");
  AST_SYNC_HOLDS: assert property (
    ctl_wr && pwdata[7] && pwdata[0] |-> ##[1:2] prescaler_held)
    else $error("sync hold did not hold prescaler");
  AST_SYNC_RELEASE: assert property (
    ctl_wr && !pwdata[7] |-> ##[1:3] !prescaler_held)
    else $error("prescaler still held after release");
  AST_RESET_RESTARTS: assert property (
    ctl_wr && pwdata[0] |-> ##4 (prescaler_taps == 4'h0) [*4])
    else $error("tap right after prescaler reset");

  COV_HELD: cover property (prescaler_held);
  COV_IRQ: cover property (irq_request != 4'h0);
  COV_SLVERR: cover property (pready && pslverr);
  COV_TAP1024: cover property (prescaler_taps[3]);
endmodule
bind timer_prescaler timer_prescaler_asserts i_timer_prescaler_asserts (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq_enable(irq_enable), .global_irq_enable(global_irq_enable), .irq_request(irq_request),
  .prescaler_taps(prescaler_taps), .prescaler_held(prescaler_held));
`default_nettype wire

// File: test/pin_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module pin_source_model (
  // clock
  input  wire logic pclk,
  // pins
  output logic      ext_timer_clock_pin,
  output logic      capture_pin_first,
  output logic      capture_pin_second
);
  // ==========================================
  // pin sources, idle low
  // ==========================================
  initial begin
    ext_timer_clock_pin = 1'b0;
    capture_pin_first   = 1'b0;
    capture_pin_second  = 1'b0;
  end

  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge pclk) ext_timer_clock_pin <= 1'b1;
      repeat (2) @(posedge pclk);
      ext_timer_clock_pin <= 1'b0;
      repeat (2) @(posedge pclk);
    end
    repeat (4) @(posedge pclk); // let the last edge reach the counter
  endtask

  // one rising then falling edge on a chosen capture pin
  task automatic cap_pulse(input logic second);
    @(posedge pclk) capture_pin_first <= !second;
    capture_pin_second <= second;
    repeat (3) @(posedge pclk);
    capture_pin_first  <= 1'b0;
    capture_pin_second <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// File: test/tb_timer_prescaler_and_flags.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_timer_prescaler_and_flags
  import timer_prescaler_pkg::*;
;
  // ==========================================
  // signals
  // ==========================================
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic        global_irq_enable, prescaler_held, ext_pin, cap_a, cap_b, clk_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0]  pstrb, irq_enable, irq_request, prescaler_taps;
  int          errors, num_checks;
  int          divs[5]   = '{1, div_8, div_64, div_256, div_1024};
  int          ext_cs[3] = '{7, 6, 0};
  int          ext_n[3]  = '{3, 3, 0};

  timer_prescaler i_timer_prescaler (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_timer_clock_pin(ext_pin),
    .capture_pin_first(cap_a), .capture_pin_second(cap_b), .irq_enable(irq_enable),
    .global_irq_enable(global_irq_enable), .irq_request(irq_request),
    .prescaler_taps(prescaler_taps), .prescaler_held(prescaler_held));

  pin_source_model i_pin_source_model (
    .pclk(pclk), .ext_timer_clock_pin(ext_pin), .capture_pin_first(cap_a), .capture_pin_second(cap_b));

  // ==========================================
  // apb master
  // ==========================================
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk) penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    rdata = prdata;
    rerr  = pslverr;
    if (n >= 50) errors++;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk); // idle cycle before the next setup
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic summarize();
    if (errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #500000;
    errors++;
    summarize();
  end

  // ==========================================
  // tests
  // ==========================================
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; pstrb = 4'hf; irq_enable = 4'h0; global_irq_enable = 1'b0; clk_en = 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(event_flags_addr); `CHK(rdata, 32'h0)
    rd(shared_control_addr); `CHK(rdata, 32'h0)
    // hold keeps the reset bit and stalls a prescaled timer
    wr(shared_control_addr, 32'hff); rd(shared_control_addr); `CHK(rdata, 32'hc1)
    `CHK(prescaler_held, 1'b1)
    wr(counter_addr, 32'h0); wr(timer_config_addr, 32'(cs_div8));
    repeat (100) @(posedge pclk);
    rd(counter_addr); `CHK(rdata, 32'h0)
    wr(shared_control_addr, 32'h40); rd(shared_control_addr); `CHK(rdata, 32'h40)
    repeat (100) @(posedge pclk);
    rd(counter_addr); `CHK(rdata != 32'h0, 1'b1)
    wr(shared_control_addr, 32'h01); rd(shared_control_addr); `CHK(rdata, 32'h0)
    // every internal tap over a fixed span
    for (int i = 0; i < 5; i++) begin
      wr(timer_config_addr, 32'h0); wr(counter_addr, 32'h0);
      wr(timer_config_addr, 32'(i + 1));
      repeat (2048) @(posedge pclk);
      wr(timer_config_addr, 32'h0); rd(counter_addr);
      `CHK((rdata >= 2048 / divs[i] - 1) && (rdata <= 2060 / divs[i] + 1), 1'b1)
    end
    // clock enable low freezes the counter: one tick before, three after the pause
    wr(counter_addr, 32'h0); wr(timer_config_addr, 32'(cs_div1));
    clk_en <= 1'b0;
    repeat (50) @(posedge pclk);
    clk_en <= 1'b1;
    wr(timer_config_addr, 32'h0); rd(counter_addr); `CHK(rdata, 32'h4)
    // external edges, undivided, and stopped
    for (int i = 0; i < 3; i++) begin
      wr(counter_addr, 32'h0); wr(timer_config_addr, 32'(ext_cs[i]));
      i_pin_source_model.ext_pulses(3);
      wr(timer_config_addr, 32'h0); rd(counter_addr); `CHK(rdata, 32'(ext_n[i]))
    end
    // compare matches, interrupts, clearing
    irq_enable <= 4'hf; global_irq_enable <= 1'b1;
    wr(compare_a_addr, 32'h12); wr(compare_b_addr, 32'h14); wr(counter_addr, 32'h10);
    wr(event_flags_addr, 32'hff); wr(timer_config_addr, 32'(cs_div1));
    repeat (20) @(posedge pclk);
    wr(timer_config_addr, 32'h0); rd(event_flags_addr); `CHK(rdata, 32'h6)
    `CHK(irq_request, 4'h6)
    wr(event_flags_addr, 32'h02); rd(event_flags_addr); `CHK(rdata, 32'h4)
    wr(vector_ack_addr, 32'h04); rd(event_flags_addr); `CHK(rdata, 32'h0)
    // overflow, then masking by the global enable
    wr(counter_addr, 32'hfffe); wr(timer_config_addr, 32'(cs_div1));
    repeat (8) @(posedge pclk);
    wr(timer_config_addr, 32'h0); rd(event_flags_addr); `CHK(rdata, 32'h1)
    `CHK(irq_request, 4'h1)
    global_irq_enable <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK(irq_request, 4'h0)
    // forced compares set nothing and read back zero
    wr(event_flags_addr, 32'hff); wr(timer_config_addr, 32'h300);
    rd(timer_config_addr); `CHK(rdata, 32'h0)
    rd(event_flags_addr); `CHK(rdata, 32'h0)
    // capture pin selection, rising edge, counting
    wr(timer_config_addr, 32'h401);
    for (int s = 0; s < 2; s++) begin
      wr(shared_control_addr, 32'(s << 6)); wr(event_flags_addr, 32'hff);
      i_pin_source_model.cap_pulse(s == 0);
      rd(event_flags_addr); `CHK(rdata & 32'h20, 32'h0)
      i_pin_source_model.cap_pulse(s == 1);
      rd(event_flags_addr); `CHK(rdata & 32'h20, 32'h20)
    end
    // capture register as top: reaching it sets capture and wrap flags
    wr(timer_config_addr, 32'h0); wr(capture_addr, 32'h5); wr(counter_addr, 32'h0);
    wr(event_flags_addr, 32'hff); wr(timer_config_addr, 32'h61);
    repeat (4) @(posedge pclk);
    wr(timer_config_addr, 32'h0); rd(event_flags_addr); `CHK(rdata, 32'h21)
    // unmapped address is refused
    rd(12'h020); `CHK({rerr, rdata}, 33'h1_0000_0000)
    summarize();
  end
endmodule
`default_nettype wire
